//--- src/iqc_bank.sv
/*
 * IQ correction and coarse mixer configuration bank with APB slave,
 * four channel correction stages and two coarse mixer rotators.
 * Assumes an APB master on the same clock; fifo_sync arrives from a pin.
 */
// Overview of operation
// - FIFO sync event loads 3-bit preset into read pointer; preset resets to 100.
// - Channel B offset is 13 bits 12:0, DAC LSB units, reset zero.
// - Channel C offset is 13 bits 12:0, reset zero, upper bits zero.
// - Channel D offset is 13 bits 12:0 at its own address, reset zero.
// - With auto-sync enabled, writing channel C offset raises auto-sync.
// - That auto-sync loads C and D offsets into datapath together.
// - Writing D offset alone leaves the applied offset unchanged.
// - Channel A gain is 11 bits 10:0, resets to one, upper bits zero.
// - Gain words are unsigned multipliers from 0 to 1.9990.
// - Binary point of gain lies between bits 9 and 10.
// - Channel B gain 11 bits 10:0 shares register with mixer, resets one.
// - Mixer bits: 15 +fs/8, 14 +fs/4, 13 fs/2, 12 -fs/4; reset 0000.
// - All enabled mixer stages combine into a multiple of fs/8.
// - A offset write auto-syncs A and B offsets; B write alone inert.
`timescale 1ns/10ps
`include "iqc_consts.svh"
module iqc_bank
   import iqc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fifo_sync,
   input  wire iqc_sample_t samp_a,
   input  wire iqc_sample_t samp_b,
   input  wire iqc_sample_t samp_c,
   input  wire iqc_sample_t samp_d,
   output iqc_sample_t      dac_a,
   output iqc_sample_t      dac_b,
   output iqc_sample_t      dac_c,
   output iqc_sample_t      dac_d,
   output iqc_phase_t       fifo_rd_ptr,
   output iqc_phase_t       mix_phase
);
   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   iqc_offset_t                 chan_a_offset_value_q;
   iqc_offset_t                 chan_b_offset_value_q;
   iqc_offset_t                 chan_c_offset_value_q;
   iqc_offset_t                 chan_d_offset_value_q;
   iqc_gain_t                   chan_a_gain_value_q;
   iqc_gain_t                   chan_b_gain_value_q;
   logic [`IQC_PRESET_W-1:0]    preset_q;
   logic [`IQC_MIX_W-1:0]       mix_mode_q;
   logic                        auto_sync_en_q;
   iqc_offset_t                 act_a_q;
   iqc_offset_t                 act_b_q;
   iqc_offset_t                 act_c_q;
   iqc_offset_t                 act_d_q;
   logic [2:0]                  sync_pipe_q;
   logic                        sync_level_q;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   logic [5:0]  idx;
   logic        mapped;
   logic        setup;
   logic        wr_take;
   logic        sync_ab;
   logic        sync_cd;
   logic        pin_sync;
   logic [31:0] rd_d;
   logic [2:0]  step;

   assign idx     = paddr[7:2];
   assign setup   = psel & ~penable;
   assign wr_take = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      mapped = 1'b1;
      rd_d   = 32'h0000_0000;
      if (paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end else begin
         unique case (idx)
            `IQC_IDX_A_OFFSET:     rd_d[12:0] = chan_a_offset_value_q;
            `IQC_IDX_PRESET_B_OFF: begin
               rd_d[15:`IQC_PRESET_LSB] = preset_q;
               rd_d[12:0]               = chan_b_offset_value_q;
            end
            `IQC_IDX_C_OFFSET:     rd_d[12:0] = chan_c_offset_value_q;
            `IQC_IDX_D_OFFSET:     rd_d[12:0] = chan_d_offset_value_q;
            `IQC_IDX_A_GAIN:       rd_d[10:0] = chan_a_gain_value_q;
            `IQC_IDX_MIX_B_GAIN:   begin
               rd_d[15:`IQC_MIX_LSB] = mix_mode_q;
               rd_d[10:0]            = chan_b_gain_value_q;
            end
            // Pointer snapshot taken at setup; it moves every clock
            `IQC_IDX_SYNC_CTRL:    begin
               rd_d[`IQC_AUTO_EN_BIT]        = auto_sync_en_q;
               rd_d[`IQC_RDPTR_LSB+2:`IQC_RDPTR_LSB] = fifo_rd_ptr;
            end
            default:               mapped = 1'b0;
         endcase
      end
   end

   // Single access cycle: answer prepared during setup
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register writes; reserved bits dropped
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chan_a_offset_value_q <= `IQC_RST_OFFSET;
         chan_b_offset_value_q <= `IQC_RST_OFFSET;
         chan_c_offset_value_q <= `IQC_RST_OFFSET;
         chan_d_offset_value_q <= `IQC_RST_OFFSET;
         chan_a_gain_value_q   <= `IQC_RST_GAIN;
         chan_b_gain_value_q   <= `IQC_RST_GAIN;
         preset_q              <= `IQC_RST_PRESET;
         mix_mode_q            <= `IQC_RST_MIX;
         auto_sync_en_q        <= 1'b0;
      end else if (wr_take) begin
         unique case (idx)
            `IQC_IDX_A_OFFSET:     chan_a_offset_value_q <= pwdata[12:0];
            `IQC_IDX_PRESET_B_OFF: begin
               preset_q              <= pwdata[15:`IQC_PRESET_LSB];
               chan_b_offset_value_q <= pwdata[12:0];
            end
            `IQC_IDX_C_OFFSET:     chan_c_offset_value_q <= pwdata[12:0];
            `IQC_IDX_D_OFFSET:     chan_d_offset_value_q <= pwdata[12:0];
            `IQC_IDX_A_GAIN:       chan_a_gain_value_q   <= pwdata[10:0];
            `IQC_IDX_MIX_B_GAIN:   begin
               mix_mode_q          <= pwdata[15:`IQC_MIX_LSB];
               chan_b_gain_value_q <= pwdata[10:0];
            end
            `IQC_IDX_SYNC_CTRL:    auto_sync_en_q <= pwdata[`IQC_AUTO_EN_BIT];
            default:               ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Sync events
   // ----------------------------------------------------------------------
   // Three-stage pin synchroniser; only the agreed level is used
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync_pipe_q  <= 3'h0;
         sync_level_q <= 1'b0;
      end else begin
         sync_pipe_q <= {sync_pipe_q[1:0], fifo_sync};
         if (sync_pipe_q[1] == sync_pipe_q[2]) begin
            sync_level_q <= sync_pipe_q[2];
         end
      end
   end

   // Rising edge once stages two and three agree
   assign pin_sync = (sync_pipe_q[1] == sync_pipe_q[2]) & sync_pipe_q[2] & ~sync_level_q;
   assign sync_cd  = wr_take & auto_sync_en_q & (idx == `IQC_IDX_C_OFFSET);
   assign sync_ab  = wr_take & auto_sync_en_q & (idx == `IQC_IDX_A_OFFSET);

   // Applied offsets move only on a sync; pwdata feeds the written channel
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         act_a_q <= `IQC_RST_OFFSET;
         act_b_q <= `IQC_RST_OFFSET;
         act_c_q <= `IQC_RST_OFFSET;
         act_d_q <= `IQC_RST_OFFSET;
      end else begin
         if (sync_ab) begin
            act_a_q <= pwdata[12:0];
            act_b_q <= chan_b_offset_value_q;
         end else if (pin_sync) begin
            act_a_q <= chan_a_offset_value_q;
            act_b_q <= chan_b_offset_value_q;
         end
         if (sync_cd) begin
            act_c_q <= pwdata[12:0];
            act_d_q <= chan_d_offset_value_q;
         end else if (pin_sync) begin
            act_c_q <= chan_c_offset_value_q;
            act_d_q <= chan_d_offset_value_q;
         end
      end
   end

   // FIFO read pointer: preset on sync, else advance
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fifo_rd_ptr <= `IQC_RST_PRESET;
      end else if (pin_sync) begin
         fifo_rd_ptr <= preset_q;
      end else begin
         fifo_rd_ptr <= fifo_rd_ptr + 3'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Coarse mixer phase
   // ----------------------------------------------------------------------
   always_comb begin
      step = 3'h0;
      if (mix_mode_q[3]) step = step + `IQC_STEP_FS8;
      if (mix_mode_q[2]) step = step + `IQC_STEP_FS4;
      if (mix_mode_q[1]) step = step + `IQC_STEP_FS2;
      if (mix_mode_q[0]) step = step + `IQC_STEP_MFS4;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mix_phase <= 3'h0;
      end else begin
         mix_phase <= mix_phase + step;
      end
   end

   // ----------------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------------
   iqc_chan_if ch_a ();
   iqc_chan_if ch_b ();
   iqc_chan_if ch_c ();
   iqc_chan_if ch_d ();

   assign ch_a.sample = samp_a;
   assign ch_a.gain   = chan_a_gain_value_q;
   assign ch_a.offset = act_a_q;
   assign ch_b.sample = samp_b;
   assign ch_b.gain   = chan_b_gain_value_q;
   assign ch_b.offset = act_b_q;
   // Gains for C and D live outside this bank; unity here
   assign ch_c.sample = samp_c;
   assign ch_c.gain   = `IQC_RST_GAIN;
   assign ch_c.offset = act_c_q;
   assign ch_d.sample = samp_d;
   assign ch_d.gain   = `IQC_RST_GAIN;
   assign ch_d.offset = act_d_q;

   iqc_chan u_chan_a (
      .clock  (clock),
      .resetn (resetn),
      .chan   (ch_a.core)
   );

   iqc_chan u_chan_b (
      .clock  (clock),
      .resetn (resetn),
      .chan   (ch_b.core)
   );

   iqc_chan u_chan_c (
      .clock  (clock),
      .resetn (resetn),
      .chan   (ch_c.core)
   );

   iqc_chan u_chan_d (
      .clock  (clock),
      .resetn (resetn),
      .chan   (ch_d.core)
   );

   iqc_rot u_rot_ab (
      .clock  (clock),
      .resetn (resetn),
      .in_i   (ch_a.result),
      .in_q   (ch_b.result),
      .phase  (mix_phase),
      .out_i  (dac_a),
      .out_q  (dac_b)
   );

   iqc_rot u_rot_cd (
      .clock  (clock),
      .resetn (resetn),
      .in_i   (ch_c.result),
      .in_q   (ch_d.result),
      .phase  (mix_phase),
      .out_i  (dac_c),
      .out_q  (dac_d)
   );
endmodule : iqc_bank

//--- pkg/iqc_consts.svh
/*
 * Register indices, field positions, reset values and datapath constants
 * for the IQ correction and coarse mixer configuration bank.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef IQC_CONSTS_SVH
`define IQC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IQC_IDX_A_OFFSET      6'h08
`define IQC_IDX_PRESET_B_OFF  6'h09
`define IQC_IDX_C_OFFSET      6'h0A
`define IQC_IDX_D_OFFSET      6'h0B
`define IQC_IDX_A_GAIN        6'h0C
`define IQC_IDX_MIX_B_GAIN    6'h0D
`define IQC_IDX_SYNC_CTRL     6'h1E

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define IQC_OFFSET_W          13
`define IQC_GAIN_W            11
`define IQC_PRESET_W          3
`define IQC_PRESET_LSB        13
`define IQC_MIX_LSB           12
`define IQC_MIX_W             4
`define IQC_GAIN_FRAC         10
`define IQC_AUTO_EN_BIT       0
`define IQC_RDPTR_LSB         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IQC_RST_PRESET        3'h4
`define IQC_RST_OFFSET        13'h0000
`define IQC_RST_GAIN          11'h400
`define IQC_RST_MIX           4'h0

// ----------------------------------------------------------------------
// Mixer phase steps in eighths of the sample rate
// ----------------------------------------------------------------------
`define IQC_STEP_FS8          3'h1
`define IQC_STEP_FS4          3'h2
`define IQC_STEP_FS2          3'h4
`define IQC_STEP_MFS4         3'h6
`define IQC_COS45             9'h0B5
`define IQC_COS45_SHIFT       8

`endif

//--- pkg/iqc_pkg.sv
/*
 * Types and a saturation helper shared by the correction bank modules.
 * Assumes the constants header is on the include path.
 */
package iqc_pkg;
   `include "iqc_consts.svh"

   typedef logic signed [15:0]              iqc_sample_t;
   typedef logic [`IQC_GAIN_W-1:0]          iqc_gain_t;
   typedef logic signed [`IQC_OFFSET_W-1:0] iqc_offset_t;
   typedef logic [2:0]                      iqc_phase_t;

   // Clamp a 19-bit signed value to the 16-bit sample range
   function automatic iqc_sample_t iqc_sat(input logic signed [18:0] v);
      if (v > 19'sh07FFF) begin
         iqc_sat = 16'sh7FFF;
      end else if (v < -19'sh08000) begin
         iqc_sat = -16'sh8000;
      end else begin
         iqc_sat = v[15:0];
      end
   endfunction : iqc_sat
endpackage : iqc_pkg

//--- pkg/iqc_chan_if.sv
/*
 * Carrier between the bank top and one channel correction stage.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface iqc_chan_if;
   import iqc_pkg::*;
   iqc_sample_t sample;
   iqc_gain_t   gain;
   iqc_offset_t offset;
   iqc_sample_t result;
   modport core (input sample, input gain, input offset, output result);
   modport ctrl (output sample, output gain, output offset, input result);
endinterface : iqc_chan_if

//--- src/iqc_chan.sv
/*
 * One channel correction stage: unsigned gain in 1.10 format, then offset,
 * then saturation, registered.
 * Assumes gain and offset are held steady by the register bank.
 */
`timescale 1ns/10ps
`include "iqc_consts.svh"
module iqc_chan
   import iqc_pkg::*;
(
   input  wire logic clock,
   input  wire logic resetn,
   iqc_chan_if.core  chan
);
   logic signed [27:0] prod;
   logic signed [17:0] scaled;
   logic signed [18:0] sum;

   // Gain then offset
   always_comb begin
      prod   = chan.sample * $signed({1'b0, chan.gain});
      scaled = prod[27:`IQC_GAIN_FRAC];
      sum    = {scaled[17], scaled} + {{6{chan.offset[12]}}, chan.offset};
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chan.result <= 16'sh0000;
      end else begin
         chan.result <= iqc_sat(sum);
      end
   end
endmodule : iqc_chan

//--- src/iqc_rot.sv
/*
 * Coarse mixer rotator for one I/Q pair: rotates by phase times 45 degrees.
 * Assumes phase advances once per sample in the parent.
 */
`timescale 1ns/10ps
`include "iqc_consts.svh"
module iqc_rot
   import iqc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire iqc_sample_t in_i,
   input  wire iqc_sample_t in_q,
   input  wire iqc_phase_t  phase,
   output iqc_sample_t      out_i,
   output iqc_sample_t      out_q
);
   logic signed [16:0] dif;
   logic signed [16:0] sm;
   logic signed [25:0] pd;
   logic signed [25:0] ps;
   logic signed [17:0] a;
   logic signed [17:0] b;
   logic signed [18:0] ri;
   logic signed [18:0] rq;

   always_comb begin
      dif = {in_i[15], in_i} - {in_q[15], in_q};
      sm  = {in_i[15], in_i} + {in_q[15], in_q};
      pd  = dif * $signed({1'b0, `IQC_COS45});
      ps  = sm * $signed({1'b0, `IQC_COS45});
      // Odd phase: extra 45 degree step
      if (phase[0]) begin
         a = pd[25:`IQC_COS45_SHIFT];
         b = ps[25:`IQC_COS45_SHIFT];
      end else begin
         a = {{2{in_i[15]}}, in_i};
         b = {{2{in_q[15]}}, in_q};
      end
      // Quadrant step
      unique case (phase[2:1])
         2'h0: begin
            ri = {a[17], a};
            rq = {b[17], b};
         end
         2'h1: begin
            ri = -{b[17], b};
            rq = {a[17], a};
         end
         2'h2: begin
            ri = -{a[17], a};
            rq = -{b[17], b};
         end
         2'h3: begin
            ri = {b[17], b};
            rq = -{a[17], a};
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         out_i <= 16'sh0000;
         out_q <= 16'sh0000;
      end else begin
         out_i <= iqc_sat(ri);
         out_q <= iqc_sat(rq);
      end
   end
endmodule : iqc_rot

//--- dv/iqc_bank_sva.sv
/*
 * Checker for the correction bank: APB answer timing, read masks, pointer.
 * Assumes binding to iqc_bank on its single clock.
 */
`timescale 1ns/10ps
module iqc_bank_sva
   import iqc_pkg::*;
(
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fifo_sync,
   input wire iqc_phase_t  fifo_rd_ptr
);
   logic [2:0] quiet_q;
   logic       pin_q;
   logic       rd;

   assign rd = pready && !pwrite;

   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // Cycles since the sync pin last moved
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         quiet_q <= 3'h0;
         pin_q   <= 1'b0;
      end else begin
         pin_q <= fifo_sync;
         if (pin_q != fifo_sync) begin
            quiet_q <= 3'h0;
         end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
         end
      end
   end

   property p_ready_pulse;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one pulse");
   property p_err_align;
      psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
   endproperty
   a_err_align: assert property (p_err_align) else $error("misaligned not refused");
   property p_err_unmapped;
      psel && !penable && !pwrite && paddr == 8'h38 |=> pslverr && prdata == 32'h0;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped read");
   property p_upper_zero;
      rd |-> prdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_off_mask;
      rd && (paddr == 8'h20 || paddr == 8'h28 || paddr == 8'h2C) |-> prdata[15:13] == 3'h0;
   endproperty
   a_off_mask: assert property (p_off_mask) else $error("offset reserved bits set");
   property p_gain_mask;
      rd && paddr == 8'h30 |-> prdata[15:11] == 5'h0;
   endproperty
   a_gain_mask: assert property (p_gain_mask) else $error("gain reserved bits set");
   property p_mix_mask;
      rd && paddr == 8'h34 |-> !prdata[11];
   endproperty
   a_mix_mask: assert property (p_mix_mask) else $error("mixer reserved bit set");
   property p_d_mapped;
      psel && !penable && paddr == 8'h2C |=> !pslverr;
   endproperty
   a_d_mapped: assert property (p_d_mapped) else $error("D offset refused");
   property p_ptr_step;
      quiet_q == 3'h7 |-> fifo_rd_ptr == $past(fifo_rd_ptr) + 3'h1;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("read pointer step wrong");
endmodule : iqc_bank_sva

bind iqc_bank iqc_bank_sva i_sva (.clock(clock), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fifo_sync(fifo_sync), .fifo_rd_ptr(fifo_rd_ptr));

//--- dv/iqc_bank_test.sv
/*
 * Self-checking bench for the correction bank over APB.
 * Assumes the checker is bound; one 25 MHz clock.
 */
`timescale 1ns/10ps
module iqc_bank_test;
   import iqc_pkg::*;
   logic        clock, resetn, psel, penable, pwrite, fifo_sync, found;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] ev;
   logic        pready, pslverr;
   iqc_sample_t smp [4];
   iqc_sample_t dac [4];
   iqc_phase_t  fifo_rd_ptr, mix_phase, ph, st;
   iqc_gain_t   gn [4];
   logic [12:0] off [4], r [4];
   logic [33:0] notes [$];
   logic [7:0]  ad [6]  = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
   logic [15:0] rst [6] = '{16'h0, 16'h8000, 16'h0, 16'h0, 16'h0400, 16'h0400};
   logic [15:0] msk [6] = '{16'h1FFF, 16'hFFFF, 16'h1FFF, 16'h1FFF, 16'h07FF, 16'h07FF};
   int          fail_count, checked, n;
   integer      seed;

   iqc_bank i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fifo_sync(fifo_sync), .samp_a(smp[0]), .samp_b(smp[1]),
      .samp_c(smp[2]), .samp_d(smp[3]), .dac_a(dac[0]), .dac_b(dac[1]), .dac_c(dac[2]),
      .dac_d(dac[3]), .fifo_rd_ptr(fifo_rd_ptr), .mix_phase(mix_phase));

   always #20 clock = ~clock;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [15:0] exp, input logic err);
      int k;
      @(posedge clock);
      notes.push_back({wr, err, 16'h0, exp});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 8);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         wrap_up();
      end
   endtask : apb

   function automatic logic [15:0] exp_dac(input logic signed [15:0] s,
                                           input logic [10:0] g, input logic [12:0] o);
      logic signed [31:0] v;
      v = (s * $signed({1'b0, g})) >>> 10;
      v = v + $signed(o);
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return v[15:0];
   endfunction : exp_dac

   // Pair rotation by phase times 45 degrees, I in the upper half
   function automatic logic [31:0] exp_rot(input logic signed [15:0] si,
                                           input logic signed [15:0] sq, input logic [2:0] p);
      logic signed [31:0] a, b, t;
      a = si;
      b = sq;
      if (p[0]) begin
         t = ((a - b) * 32'sh0B5) >>> 8;
         b = ((a + b) * 32'sh0B5) >>> 8;
         a = t;
      end
      for (int k = 0; k < p[2:1]; k++) begin
         t = a;
         a = -b;
         b = t;
      end
      a = (a > 32767) ? 32767 : (a < -32768) ? -32768 : a;
      b = (b > 32767) ? 32767 : (b < -32768) ? -32768 : b;
      return {a[15:0], b[15:0]};
   endfunction : exp_rot

   task automatic check_dac;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         check("dac", {16'h0, dac[i]}, {16'h0, exp_dac(smp[i], gn[i], off[i])});
      end
   endtask : check_dac

   // Completed transfers against the oldest note
   always @(posedge clock) begin
      logic [33:0] nt;
      if (psel && penable && pready) begin
         nt = notes.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, nt[32]});
         if (!nt[33]) check("prdata", prdata, nt[31:0]);
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fifo_sync = 1'b0;
      smp = '{default: 16'h0};
      gn = '{default: 11'h400};
      off = '{default: 13'h0};
      seed = 32'hF4EF5A6F;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++) apb(1'b0, ad[i], 32'h0, rst[i], 1'b0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ad[i], {16'hFFFF, i == 5 ? 16'h0FFF : 16'hFFFF}, 16'h0, 1'b0);
         apb(1'b0, ad[i], 32'h0, msk[i], 1'b0);
      end
      apb(1'b0, 8'h38, 32'h0, 16'h0, 1'b1);
      apb(1'b1, 8'h22, 32'h1, 16'h0, 1'b1);
      $display("test registers done");
      gn[0] = 11'h7FF;
      gn[1] = 11'h7FF;
      for (int i = 0; i < 4; i++) smp[i] <= 16'($random(seed));
      check_dac();
      apb(1'b1, 8'h78, 32'h1, 16'h0, 1'b0);
      for (int i = 0; i < 4; i++) r[i] = 13'($random(seed));
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, k ? 8'h24 : 8'h2C, {16'h0, 3'h5, r[3-2*k]}, 16'h0, 1'b0);
         check_dac();
         apb(1'b1, k ? 8'h20 : 8'h28, {16'h0, 3'h7, r[2-2*k]}, 16'h0, 1'b0);
         off[2-2*k] = r[2-2*k];
         off[3-2*k] = r[3-2*k];
         check_dac();
      end
      $display("test offsets done");
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (fifo_rd_ptr !== 3'h5 && n < 16);
      if (fifo_rd_ptr !== 3'h5) begin
         fail_count++;
         wrap_up();
      end
      fifo_sync <= 1'b1;
      found = 1'b0;
      repeat (7) begin
         @(posedge clock);
         if (fifo_rd_ptr === 3'h5) found = 1'b1;
      end
      check("rd_ptr", {31'h0, found}, 32'h1);
      fifo_sync <= 1'b0;
      repeat (8) @(posedge clock);
      $display("test sync done");
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 8'h34, {16'h0, c[3:0], 1'b0, gn[1]}, 16'h0, 1'b0);
         repeat (2) @(posedge clock);
         ph = mix_phase;
         @(posedge clock);
         st = (c[3] ? 3'h1 : 3'h0) + (c[2] ? 3'h2 : 3'h0) + (c[1] ? 3'h4 : 3'h0) +
              (c[0] ? 3'h6 : 3'h0);
         check("mix_step", {29'h0, 3'(mix_phase - ph)}, {29'h0, st});
      end
      apb(1'b1, 8'h34, {16'h0, 4'h5, 1'b0, gn[1]}, 16'h0, 1'b0);
      repeat (3) @(posedge clock);
      for (int i = 0; i < 4; i += 2) begin
         ev = exp_rot(exp_dac(smp[i], gn[i], off[i]),
                      exp_dac(smp[i+1], gn[i+1], off[i+1]), mix_phase);
         check("rot_i", {16'h0, dac[i]}, {16'h0, ev[31:16]});
         check("rot_q", {16'h0, dac[i+1]}, {16'h0, ev[15:0]});
      end
      $display("test mixer done");
      wrap_up();
   end
endmodule : iqc_bank_test
